// *** ptpc_top.sv ***
// periodic timer: pwm, single pulse, capture and compare, axi4-lite regs
// Summary of operation
// - pwm period is compare_p_value, or 1024 counts when it is zero
// - duty at or above the period gives an output active all period
// - pwm counting continues while pin function forces the output level
// - clear_source_bit is ignored in pwm mode; period match clears
// - rising counter_run_bit starts the counter and the pulse leading edge
// - ext_clock_pin active edge sets counter_run_bit in single pulse mode
// - compare a match ends the pulse, clears run bit, raises an event
// - single pulse counter clears only on run rise; period, clear source unused
// - mode 01 is capture; capture_pin_select picks pin a, b or ext
// - pin function picks rising, falling, both; 11 blocks all captures
// - each selected edge copies the counter into compare_a_value, event
// - capture counter starts on run rise and counts while run is set and pause is clear
// - capture period match clears counter with event; zero gives full count
// - capture ignores clear source, init level, invert; no output
// - capture pin edges count even when that pin is driven as output
// - pwm init level sets active polarity, invert flips the output
`timescale 1ns/1ps
module ptpc_top (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic [7:0]  I_AXI_AWADDR,
    input  wire logic        I_AXI_AWVALID,
    output logic             O_AXI_AWREADY,
    input  wire logic [31:0] I_AXI_WDATA,
    input  wire logic [3:0]  I_AXI_WSTRB,
    input  wire logic        I_AXI_WVALID,
    output logic             O_AXI_WREADY,
    output logic [1:0]       O_AXI_BRESP,
    output logic             O_AXI_BVALID,
    input  wire logic        I_AXI_BREADY,
    input  wire logic [7:0]  I_AXI_ARADDR,
    input  wire logic        I_AXI_ARVALID,
    output logic             O_AXI_ARREADY,
    output logic [31:0]      O_AXI_RDATA,
    output logic [1:0]       O_AXI_RRESP,
    output logic             O_AXI_RVALID,
    input  wire logic        I_AXI_RREADY,
    input  wire logic        I_TIMER_PIN_A,
    input  wire logic        I_TIMER_PIN_B,
    input  wire logic        I_EXT_CLOCK_PIN,
    output logic             O_TIMER_OUT,
    output logic             O_TIMER_OUT_EN_N,
    output logic             O_TIMER_EVENT
);
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        arready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  ctl0;
        logic [7:0]  ctl1;
        logic [9:0]  cnt;
        logic [9:0]  cmp_a;
        logic [9:0]  cmp_p;
        logic        a_flag;
        logic        p_flag;
        logic        run_prev;
        logic        cmp_lvl;
        logic        pin_out;
        logic        pin_en_n;
        logic        event_pulse;
    } ptpc_state_t;

    ptpc_state_t st_reg;
    ptpc_state_t st_next;

    ptpc_evt_if evt ();

    ptpc_sync u_sync (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_SYS_RST),
        .i_pins ({I_EXT_CLOCK_PIN, I_TIMER_PIN_B, I_TIMER_PIN_A}),
        .evt    (evt)
    );

    ptpc_tick u_tick (
        .i_clk (I_SYS_CLK),
        .i_rst (I_SYS_RST),
        .evt   (evt)
    );

    assign evt.clk_sel = st_reg.ctl0[ptpc_pkg::C0_CKSEL +: 3];

    // merge a write word into a register image under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (data & m);
    endfunction

    function automatic logic [31:0] read_word(input ptpc_state_t s,
                                              input logic [7:0]  a);
        unique case (a)
            ptpc_pkg::OFS_CTL0:   return {24'h000000, s.ctl0};
            ptpc_pkg::OFS_CTL1:   return {24'h000000, s.ctl1};
            ptpc_pkg::OFS_COUNT:  return {22'h000000, s.cnt};
            ptpc_pkg::OFS_CMP_A:  return {22'h000000, s.cmp_a};
            ptpc_pkg::OFS_CMP_P:  return {22'h000000, s.cmp_p};
            ptpc_pkg::OFS_STATUS: return {30'h00000000, s.p_flag, s.a_flag};
            default:              return 32'h00000000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == ptpc_pkg::OFS_CTL0) || (a == ptpc_pkg::OFS_CTL1) ||
               (a == ptpc_pkg::OFS_COUNT) || (a == ptpc_pkg::OFS_CMP_A) ||
               (a == ptpc_pkg::OFS_CMP_P) || (a == ptpc_pkg::OFS_STATUS);
    endfunction

    logic [1:0]  mode;
    logic [1:0]  pfunc;
    logic        run;
    logic        pause;
    logic        init_lvl;
    logic        invert;
    logic        clr_src;
    logic [1:0]  cap_sel;
    logic        single;
    logic        start;
    logic        cnt_en;
    logic [10:0] inc;
    logic [10:0] period;
    logic        p_hit;
    logic        a_hit;
    logic        cap_rise;
    logic        cap_fall;
    logic        cap_hit;
    logic        ext_edge;
    logic        active;
    logic [31:0] wword;
    logic        do_wr;
    logic [31:0] mword;

    assign mode     = st_reg.ctl1[ptpc_pkg::C1_MODE +: 2];
    assign pfunc    = st_reg.ctl1[ptpc_pkg::C1_PFUNC +: 2];
    assign init_lvl = st_reg.ctl1[ptpc_pkg::C1_INIT];
    assign invert   = st_reg.ctl1[ptpc_pkg::C1_INV];
    assign clr_src  = st_reg.ctl1[ptpc_pkg::C1_CLRSRC];
    assign run      = st_reg.ctl0[ptpc_pkg::C0_RUN];
    assign pause    = st_reg.ctl0[ptpc_pkg::C0_PAUSE];
    assign cap_sel  = st_reg.ctl0[ptpc_pkg::C0_CAPSEL +: 2];

    // both pin function bits high with mode 10 means single pulse
    assign single = (mode == ptpc_pkg::MODE_PWM) && (pfunc == ptpc_pkg::PF_11);
    assign start  = run & ~st_reg.run_prev;
    assign cnt_en = run & ~pause & evt.tick & ~start;
    assign inc    = {1'b0, st_reg.cnt} + 11'h001;
    // a zero period value lets the counter wrap after 1024 counts
    assign period = (st_reg.cmp_p == 10'h000) ? 11'h400
                                              : {1'b0, st_reg.cmp_p};
    assign p_hit  = cnt_en & (inc == period);
    assign a_hit  = cnt_en & (inc == {1'b0, st_reg.cmp_a});

    // capture source taken from the pin inputs, never from the driven output
    always_comb begin
        unique case (cap_sel)
            2'h0:    cap_rise = evt.rise[ptpc_pkg::PIN_A];
            2'h1:    cap_rise = evt.rise[ptpc_pkg::PIN_B];
            default: cap_rise = evt.rise[ptpc_pkg::PIN_EXT];
        endcase
        unique case (cap_sel)
            2'h0:    cap_fall = evt.fall[ptpc_pkg::PIN_A];
            2'h1:    cap_fall = evt.fall[ptpc_pkg::PIN_B];
            default: cap_fall = evt.fall[ptpc_pkg::PIN_EXT];
        endcase
    end

    always_comb begin
        unique case (pfunc)
            ptpc_pkg::PF_00: cap_hit = cap_rise;
            ptpc_pkg::PF_01: cap_hit = cap_fall;
            ptpc_pkg::PF_10: cap_hit = cap_rise | cap_fall;
            ptpc_pkg::PF_11: cap_hit = 1'b0;
        endcase
    end

    // the ext pin active edge follows the falling clock select
    assign ext_edge = (evt.clk_sel == ptpc_pkg::CK_EXT_F)
                    ? evt.fall[ptpc_pkg::PIN_EXT]
                    : evt.rise[ptpc_pkg::PIN_EXT];

    assign wword = st_reg.wdata;
    assign do_wr = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
    assign mword = merge(read_word(st_reg, st_reg.awaddr), wword,
                         st_reg.wstrb);

    always_comb begin
        st_next             = st_reg;
        st_next.event_pulse = 1'b0;
        st_next.run_prev    = run;

        // bus: address and data may arrive in either order
        if (I_AXI_AWVALID && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = I_AXI_WDATA;
            st_next.wstrb = I_AXI_WSTRB;
        end
        if (st_reg.bvalid && I_AXI_BREADY) begin
            st_next.bvalid = 1'b0;
        end
        if (do_wr) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = mapped(st_reg.awaddr) ? ptpc_pkg::RESP_OKAY
                                                   : ptpc_pkg::RESP_SLVERR;
            unique case (st_reg.awaddr)
                ptpc_pkg::OFS_CTL0:
                    st_next.ctl0 = mword[7:0] & ptpc_pkg::C0_MASK;
                ptpc_pkg::OFS_CTL1:
                    st_next.ctl1 = mword[7:0] & ptpc_pkg::C1_MASK;
                ptpc_pkg::OFS_CMP_A:
                    st_next.cmp_a = mword[9:0];
                ptpc_pkg::OFS_CMP_P:
                    st_next.cmp_p = mword[9:0];
                ptpc_pkg::OFS_STATUS: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.a_flag = st_reg.a_flag & ~wword[ptpc_pkg::ST_A_FLAG];
                        st_next.p_flag = st_reg.p_flag & ~wword[ptpc_pkg::ST_P_FLAG];
                    end
                end
                default: ;
            endcase
        end
        if (st_reg.rvalid && I_AXI_RREADY) begin
            st_next.rvalid = 1'b0;
        end
        if (I_AXI_ARVALID && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = read_word(st_reg, I_AXI_ARADDR);
            st_next.rresp  = mapped(I_AXI_ARADDR) ? ptpc_pkg::RESP_OKAY
                                                  : ptpc_pkg::RESP_SLVERR;
        end

        // counter: every mode restarts from zero on a run rise
        if (start) begin
            st_next.cnt     = ptpc_pkg::CNT_RST;
            st_next.cmp_lvl = init_lvl;
        end else if (cnt_en) begin
            st_next.cnt = inc[9:0];
        end

        unique case (mode)
            ptpc_pkg::MODE_PWM: begin
                if (single) begin
                    // period and clear source play no part here
                    if (a_hit) begin
                        st_next.ctl0[ptpc_pkg::C0_RUN] = 1'b0;
                        st_next.a_flag                 = 1'b1;
                        st_next.event_pulse            = 1'b1;
                    end
                    if (ext_edge) begin
                        st_next.ctl0[ptpc_pkg::C0_RUN] = 1'b1;
                    end
                end else begin
                    if (p_hit) begin
                        st_next.cnt         = ptpc_pkg::CNT_RST;
                        st_next.p_flag      = 1'b1;
                        st_next.event_pulse = 1'b1;
                    end
                    if (a_hit) begin
                        st_next.a_flag      = 1'b1;
                        st_next.event_pulse = 1'b1;
                    end
                end
            end
            ptpc_pkg::MODE_CAP: begin
                if (p_hit) begin
                    st_next.cnt         = ptpc_pkg::CNT_RST;
                    st_next.p_flag      = 1'b1;
                    st_next.event_pulse = 1'b1;
                end
                // capture wins over a software write in the same cycle
                if (cap_hit) begin
                    st_next.cmp_a       = st_reg.cnt;
                    st_next.a_flag      = 1'b1;
                    st_next.event_pulse = 1'b1;
                end
            end
            default: begin
                // compare match and plain timer modes
                if (clr_src ? a_hit : p_hit) begin
                    st_next.cnt = ptpc_pkg::CNT_RST;
                end
                if (p_hit && !clr_src) begin
                    st_next.p_flag      = 1'b1;
                    st_next.event_pulse = 1'b1;
                end
                if (a_hit) begin
                    st_next.a_flag      = 1'b1;
                    st_next.event_pulse = 1'b1;
                    unique case (pfunc)
                        ptpc_pkg::PF_01: st_next.cmp_lvl = 1'b0;
                        ptpc_pkg::PF_10: st_next.cmp_lvl = 1'b1;
                        ptpc_pkg::PF_11: st_next.cmp_lvl = ~st_reg.cmp_lvl;
                        default:         ;
                    endcase
                end
            end
        endcase

        // output pin; duty at or above the period keeps cnt below duty
        active = 1'b0;
        unique case (mode)
            ptpc_pkg::MODE_PWM: begin
                unique case (pfunc)
                    ptpc_pkg::PF_00: active = 1'b0;
                    ptpc_pkg::PF_01: active = 1'b1;
                    ptpc_pkg::PF_10: active = st_next.cnt < st_reg.cmp_a;
                    ptpc_pkg::PF_11: active = st_next.ctl0[ptpc_pkg::C0_RUN];
                endcase
                st_next.pin_out  = (active ? init_lvl : ~init_lvl) ^ invert;
                st_next.pin_en_n = 1'b0;
            end
            ptpc_pkg::MODE_CMP: begin
                st_next.pin_out  = st_next.cmp_lvl ^ invert;
                st_next.pin_en_n = 1'b0;
            end
            default: begin
                st_next.pin_out  = 1'b0;
                st_next.pin_en_n = 1'b1;
            end
        endcase

        // one write and one read outstanding at a time
        st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
        st_next.wready  = ~st_next.w_got & ~st_next.bvalid;
        st_next.arready = ~st_next.rvalid;
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            st_reg          <= '0;
            st_reg.ctl0     <= ptpc_pkg::CTL_RST;
            st_reg.ctl1     <= ptpc_pkg::CTL_RST;
            st_reg.pin_en_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_AXI_AWREADY    = st_reg.awready;
    assign O_AXI_WREADY     = st_reg.wready;
    assign O_AXI_BVALID     = st_reg.bvalid;
    assign O_AXI_BRESP      = st_reg.bresp;
    assign O_AXI_ARREADY    = st_reg.arready;
    assign O_AXI_RVALID     = st_reg.rvalid;
    assign O_AXI_RDATA      = st_reg.rdata;
    assign O_AXI_RRESP      = st_reg.rresp;
    assign O_TIMER_OUT      = st_reg.pin_out;
    assign O_TIMER_OUT_EN_N = st_reg.pin_en_n;
    assign O_TIMER_EVENT    = st_reg.event_pulse;
endmodule // ptpc_top

// *** ptpc_pkg.sv ***
// constants shared by the periodic timer files
package ptpc_pkg;
    localparam int unsigned CNT_W      = 10;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned CLK_MHZ    = 100;
    // register byte offsets
    localparam logic [7:0] OFS_CTL0    = 8'h00;
    localparam logic [7:0] OFS_CTL1    = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;
    localparam logic [7:0] OFS_CMP_A   = 8'h0c;
    localparam logic [7:0] OFS_CMP_P   = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    // control_word_zero fields
    localparam int unsigned C0_PAUSE   = 7;
    localparam int unsigned C0_CKSEL   = 4;
    localparam int unsigned C0_RUN     = 3;
    localparam int unsigned C0_CAPSEL  = 0;
    localparam logic [7:0]  C0_MASK    = 8'hfb;
    // control_word_one fields
    localparam int unsigned C1_MODE    = 6;
    localparam int unsigned C1_PFUNC   = 4;
    localparam int unsigned C1_INIT    = 3;
    localparam int unsigned C1_INV     = 2;
    localparam int unsigned C1_CLRSRC  = 0;
    localparam logic [7:0]  C1_MASK    = 8'hfd;
    // status fields, write one to clear
    localparam int unsigned ST_A_FLAG  = 0;
    localparam int unsigned ST_P_FLAG  = 1;
    // reset values
    localparam logic [7:0]  CTL_RST    = 8'h00;
    localparam logic [9:0]  CNT_RST    = 10'h000;
    // mode_select_bits encodings
    localparam logic [1:0]  MODE_CMP   = 2'h0;
    localparam logic [1:0]  MODE_CAP   = 2'h1;
    localparam logic [1:0]  MODE_PWM   = 2'h2;
    localparam logic [1:0]  MODE_TMR   = 2'h3;
    // pin_function_bits encodings
    localparam logic [1:0]  PF_00      = 2'h0;
    localparam logic [1:0]  PF_01      = 2'h1;
    localparam logic [1:0]  PF_10      = 2'h2;
    localparam logic [1:0]  PF_11      = 2'h3;
    // timer clock selects
    localparam logic [2:0]  CK_DIV4    = 3'h0;
    localparam logic [2:0]  CK_DIV1    = 3'h1;
    localparam logic [2:0]  CK_DIV16   = 3'h2;
    localparam logic [2:0]  CK_DIV64   = 3'h3;
    localparam logic [2:0]  CK_EXT_R   = 3'h6;
    localparam logic [2:0]  CK_EXT_F   = 3'h7;
    localparam logic [5:0]  PRE_RST    = 6'h00;
    // pin index of the synchronised inputs
    localparam int unsigned PIN_A      = 0;
    localparam int unsigned PIN_B      = 1;
    localparam int unsigned PIN_EXT    = 2;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** ptpc_evt_if.sv ***
// pin edges, clock select and timer tick between the timer modules
`timescale 1ns/1ps
interface ptpc_evt_if;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [2:0] clk_sel;
    logic       tick;
    modport sync (output rise, output fall);
    modport tick_gen (input rise, input fall, input clk_sel, output tick);
    modport core (input rise, input fall, input tick, output clk_sel);
endinterface

// *** ptpc_sync.sv ***
// two-stage synchronisers and edge detect for the three timer pins
`timescale 1ns/1ps
module ptpc_sync (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_pins,
    ptpc_evt_if.sync        evt
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } ptpc_sync_t;

    ptpc_sync_t st_reg;
    ptpc_sync_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = i_pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // edges look at stages two and three only
    for (genvar g = 0; g < 3; g++) begin : g_edge
        assign evt.rise[g] = st_reg.s2[g] & ~st_reg.s3[g];
        assign evt.fall[g] = ~st_reg.s2[g] & st_reg.s3[g];
    end
endmodule // ptpc_sync

// *** ptpc_tick.sv ***
// timer clock select: prescaled system clock or external pin edges
`timescale 1ns/1ps
module ptpc_tick (
    input  wire logic i_clk,
    input  wire logic i_rst,
    ptpc_evt_if.tick_gen evt
);
    typedef struct packed {
        logic [5:0] pre;
        logic       tick;
    } ptpc_tick_t;

    ptpc_tick_t st_reg;
    ptpc_tick_t st_next;

    always_comb begin
        st_next     = st_reg;
        st_next.pre = st_reg.pre + 6'h01;
        unique case (evt.clk_sel)
            ptpc_pkg::CK_DIV1:  st_next.tick = 1'b1;
            ptpc_pkg::CK_DIV16: st_next.tick = (st_reg.pre[3:0] == 4'hf);
            ptpc_pkg::CK_DIV64: st_next.tick = (st_reg.pre == 6'h3f);
            ptpc_pkg::CK_EXT_R: st_next.tick = evt.rise[ptpc_pkg::PIN_EXT];
            ptpc_pkg::CK_EXT_F: st_next.tick = evt.fall[ptpc_pkg::PIN_EXT];
            // other internal sources fall back to a divide by four
            default:  st_next.tick = (st_reg.pre[1:0] == 2'h3);
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign evt.tick = st_reg.tick;
endmodule // ptpc_tick

// *** ptpc_pin_model.sv ***
// model of the external pulse sources on the three timer pins
`timescale 1ns/1ps
module ptpc_pin_model (
    input  wire logic       i_clk,
    output logic [2:0]      o_pins
);
    initial o_pins = 3'h0;
    // pins are driven push-pull and idle low
    // each level is held six clocks so that the synchronisers catch it
    task automatic pulse(input int k);
        @(posedge i_clk);
        o_pins[k] <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_pins[k] <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
endmodule // ptpc_pin_model

// *** ptpc_top_assertions.sv ***
// bus handshake and reset checks on the timer's top ports
`timescale 1ns/1ps
module ptpc_chk (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic [7:0]  I_AXI_ARADDR,
    input  wire logic        I_AXI_ARVALID,
    input  wire logic        O_AXI_ARREADY,
    input  wire logic [31:0] O_AXI_RDATA,
    input  wire logic [1:0]  O_AXI_RRESP,
    input  wire logic        O_AXI_RVALID,
    input  wire logic        I_AXI_RREADY,
    input  wire logic        O_AXI_AWREADY,
    input  wire logic        O_AXI_WREADY,
    input  wire logic        O_AXI_BVALID,
    input  wire logic        I_AXI_BREADY,
    input  wire logic        O_TIMER_EVENT,
    input  wire logic        O_TIMER_OUT_EN_N
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    bvalid_hold_a: assert property (O_AXI_BVALID && !I_AXI_BREADY
        |=> O_AXI_BVALID) else $error("write response dropped early");
    rvalid_hold_a: assert property (O_AXI_RVALID && !I_AXI_RREADY
        |=> O_AXI_RVALID) else $error("read data dropped early");
    wr_busy_a: assert property (O_AXI_BVALID
        |-> !O_AXI_AWREADY && !O_AXI_WREADY) else $error("write ready early");
    rd_busy_a: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
        else $error("read ready while data pending");
    rd_answer_a: assert property (I_AXI_ARVALID && O_AXI_ARREADY
        |=> O_AXI_RVALID) else $error("read answer late");
    rd_unmapped_a: assert property (I_AXI_ARVALID && O_AXI_ARREADY
        && I_AXI_ARADDR > 8'h14 |=> O_AXI_RRESP == 2'h2
        && O_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
    ready_back_a: assert property (O_AXI_RVALID && I_AXI_RREADY
        |-> ##[1:2] O_AXI_ARREADY) else $error("read ready not back");
    reset_out_a: assert property ($fell(I_SYS_RST)
        |-> !O_TIMER_EVENT && O_TIMER_OUT_EN_N) else $error("bad reset out");
endmodule // ptpc_chk
bind ptpc_top ptpc_chk ptpc_chk_i (.I_SYS_CLK(I_SYS_CLK),
    .I_SYS_RST(I_SYS_RST), .I_AXI_ARADDR(I_AXI_ARADDR),
    .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
    .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RRESP(O_AXI_RRESP),
    .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY),
    .O_AXI_AWREADY(O_AXI_AWREADY), .O_AXI_WREADY(O_AXI_WREADY),
    .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
    .O_TIMER_EVENT(O_TIMER_EVENT), .O_TIMER_OUT_EN_N(O_TIMER_OUT_EN_N));

// *** test_periodic_timer_pulse_capture.sv ***
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module test_periodic_timer_pulse_capture;
    logic        clk, rst, awv, wv, bready, arv, rready;
    logic        awr, wr_r, bv, arr, rv, tout, ten, tev;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  pins;
    logic [33:0] exp_q[$];
    int          mismatches, checks_done, ev, cyc, e, a;
    ptpc_pin_model ptpc_pin_model_i (.i_clk(clk), .o_pins(pins));
    ptpc_top ptpc_top_i (.I_SYS_CLK(clk), .I_SYS_RST(rst),
        .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr),
        .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wv),
        .O_AXI_WREADY(wr_r), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv),
        .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
        .O_AXI_RVALID(rv), .I_AXI_RREADY(rready), .I_TIMER_PIN_A(pins[0]),
        .I_TIMER_PIN_B(pins[1]), .I_EXT_CLOCK_PIN(pins[2]),
        .O_TIMER_OUT(tout), .O_TIMER_OUT_EN_N(ten), .O_TIMER_EVENT(tev));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(string n, logic [33:0] x, logic [33:0] s);
        checks_done++;
        if (s !== x) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(logic [7:0] ad, logic [31:0] d, logic [1:0] r = 2'h0);
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        awaddr <= ad; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_r === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, logic [31:0] d, logic [1:0] r = 2'h0);
        exp_q.push_back({r, d});
        @(posedge clk);
        araddr <= ad; arv <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
    endtask
    // counts high output cycles over ten whole periods of four counts
    task automatic hic(int x);
        int h;
        h = 0;
        repeat (10) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            h += int'(tout === 1'b1);
        end
        chk("high_cycles", 34'(x), 34'(h));
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tev === 1'b1) ev <= ev + 1;
        if (bv === 1'b1 && bready) chk("bresp", exp_q.pop_front(), {bresp, 32'h0});
        if (rv === 1'b1 && rready) chk("rdata", exp_q.pop_front(), {rresp, rdata});
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {awv, wv, bready, arv, rready} = 5'h0;
        awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; rst = 1'b1;
        mismatches = 0; checks_done = 0; ev = 0; cyc = 0;
        void'($urandom(32'hea6d56a7));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h1, 2'h2);
        wr(8'h10, 32'h4);
        wr(8'h04, 32'ha8);
        wr(8'h00, 32'h18);
        repeat (4) begin
            a = $urandom % 6;
            wr(8'h0c, 32'(a));
            hic(a > 3 ? 40 : 10 * a);
        end
        wr(8'h0c, 32'h1);
        wr(8'h04, 32'hac);
        hic(30);
        wr(8'h04, 32'ha9);
        hic(10);
        wr(8'h04, 32'h98);
        hic(40);
        wr(8'h04, 32'h88);
        e = ev;
        hic(0);
        chk("pwm_runs", 34'h1, 34'(ev - e >= 20));
        // a stop before each start gives the run bit a clean rising edge
        for (int p = 0; p < 4; p++) begin
            wr(8'h00, 32'h10);
            wr(8'h10, 32'h0);
            wr(8'h0c, 32'h155);
            wr(8'h04, 32'h40 + 32'(p) * 32'h10);
            wr(8'h00, 32'h18 + 32'(p % 3));
            e = ev;
            ptpc_pin_model_i.pulse(p % 3);
            repeat (10) @(posedge clk);
            chk("events", 34'(p == 3 ? 0 : p / 2 + 1), 34'(ev - e));
            chk("out_en_n", 34'h1, 34'(ten));
        end
        rd(8'h0c, 32'h155);
        wr(8'h00, 32'h10);
        wr(8'h0c, 32'h6);
        wr(8'h04, 32'hb0);
        e = ev;
        wr(8'h00, 32'h18);
        chk("pulse_lvl", 34'h0, 34'(tout));
        repeat (30) @(posedge clk);
        chk("pulse_end", 34'h1, 34'(tout));
        chk("events", 34'h1, 34'(ev - e));
        rd(8'h00, 32'h10);
        e = ev;
        ptpc_pin_model_i.pulse(2);
        repeat (30) @(posedge clk);
        chk("events", 34'h1, 34'(ev - e));
        rd(8'h00, 32'h10);
        wrap_up();
    end
endmodule // test_periodic_timer_pulse_capture
